// >>> hw/sfe_ecc.sv
// sfe_ecc: byte-wide ecc shift register with hold, clear and feed.
// assumes: feed and clear come from logic on clk; clear wins over feed.
`timescale 1ns/10ps
module sfe_ecc
   import sfe_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic feed,
   input wire logic [7:0] data_byte,
   output logic [31:0] ecc
);
   logic [31:0] next_ecc;

   // eight serial shifts per byte, msb first
   always_comb begin
      next_ecc = ecc;
      for (int i = 7; i >= 0; i--) begin
         if (next_ecc[31] ^ data_byte[i]) begin
            next_ecc = {next_ecc[30:0], 1'b0} ^ ECC_POLY;
         end else begin
            next_ecc = {next_ecc[30:0], 1'b0};
         end
      end
   end

   // without feed or clear the register simply holds
   always_ff @(posedge clk) begin
      if (sys_rst || clear) begin
         ecc <= ECC_SEED;
      end else if (feed) begin
         ecc <= next_ecc;
      end
   end
endmodule // sfe_ecc

// >>> hw/sfe_seq.sv
// sfe_seq: control store sequencer with split data field ecc freeze and resume.
// assumes: classic wishbone master on clk; disk byte strobe and read data come from pins.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/10ps
module sfe_seq
   import sfe_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_HI:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic disk_byte_tick,
   input wire logic [7:0] disk_rd_data,
   output logic [7:0] disk_wr_data,
   output logic disk_read_gate,
   output logic disk_write_gate,
   input wire logic [7:0] buf_in_data,
   output logic buf_in_take,
   output logic [7:0] buf_out_data,
   output logic buf_out_push,
   output logic seq_done
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [CS_W-1:0] control_store [CS_DEPTH];
   logic tk_s1, tk_s2, tk_s3;
   logic [7:0] rd_s1, rd_s2;
   logic split_en, run, dir_wr, pend_dir, restart, frozen, first_sec, xact, ecc_err;
   logic [4:0] pc, branch, next_pc;
   logic [7:0] cnt;
   logic [31:0] synd;
   logic [31:0] ecc_q;
   logic [CS_W-1:0] cur, nxt_word;
   logic [7:0] w_cnt, w_dat, ecc_byte;
   logic [4:0] w_nxt, tgt;
   logic w_xfer, w_gate, w_am, w_stop, split_act, tick, byte_ev, word_end, stop_now;
   logic nxt_xfer, freeze, resume, term, ecc_feed, ecc_clr, launch, load;
   logic req, wr, cs_hit, go_wr, launch_dir, term_q;
   logic [7:0] idx;
   logic [31:0] lane_m, rd_val;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: disk strobe and read data pass two flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tk_s1 <= 1'b0;
         tk_s2 <= 1'b0;
         tk_s3 <= 1'b0;
         rd_s1 <= 8'h00;
         rd_s2 <= 8'h00;
      end else begin
         tk_s1 <= disk_byte_tick;
         tk_s2 <= tk_s1;
         tk_s3 <= tk_s2;
         rd_s1 <= disk_rd_data;
         rd_s2 <= rd_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // current word decode
   assign cur = control_store[pc];
   assign w_cnt = cur[W_CNT+:8];
   assign w_nxt = cur[W_NXT+:5];
   assign w_dat = cur[W_DAT+:8];
   assign w_xfer = cur[C_XFER];
   assign w_gate = cur[C_GATE];
   assign w_am = cur[C_AM] & ~cur[C_XFER];
   assign w_stop = cur[C_STOP];
   assign split_act = split_en & cur[C_SPLIT];

   // byte timing: every word, gap or section, lasts count+1 byte strobes
   assign tick = tk_s2 & ~tk_s3;
   assign byte_ev = run & tick;
   assign word_end = byte_ev & (cnt == 8'h00);
   assign tgt = (w_nxt == JUMP_CODE) ? branch : w_nxt;
   assign stop_now = word_end & (w_stop | (tgt == JUMP_CODE));
   assign nxt_word = (tgt == JUMP_CODE) ? '0 : control_store[tgt];
   assign nxt_xfer = nxt_word[C_XFER];

   // ecc steering: freeze at end of a flagged transfer word, resume on a flagged
   // non-transfer word, terminate at the end of an unflagged final transfer word
   assign freeze = word_end & w_xfer & split_act;
   assign resume = word_end & ~w_xfer & split_act;
   assign term = word_end & w_xfer & ~split_act & (stop_now | ~nxt_xfer);
   assign ecc_feed = byte_ev & ~frozen & (w_xfer | (w_am & first_sec));
   assign ecc_byte = dir_wr ? (w_xfer ? buf_in_data : w_dat) : rd_s2;
   // the final byte of a sector is fed at the terminating edge, so the clear waits a cycle
   assign ecc_clr = term_q | (launch & ~term);

   // start and chained restart
   assign launch = (go_wr & (~run | stop_now)) | (stop_now & restart);
   assign launch_dir = go_wr ? wb_dat_i[G_WRITE] : pend_dir;
   assign load = launch | (word_end & ~stop_now);
   assign next_pc = launch ? PC_START : tgt;

   ////////////////////////////////////////////////////////////////////////////////
   // wishbone decode
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i;
   assign idx = wb_adr_i[ADR_HI:ADR_LO];
   assign cs_hit = idx < IX_CS_END;
   assign go_wr = wr & (idx == IX_START) & wb_sel_i[0] & wb_dat_i[G_GO];
   assign lane_m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign rd_val = cs_hit ? {{(32-CS_W){1'b0}}, control_store[idx[4:0]]} :
                   (idx == IX_AUX) ? {24'h000000, split_en, 7'h00} :
                   (idx == IX_BRANCH) ? {27'h0, branch} :
                   (idx == IX_STATUS) ? {24'h000000, run, xact, 5'h00, ecc_err} :
                   (idx == IX_START) ? {30'h0, pend_dir, run} :
                   (idx == IX_SYND) ? synd : 32'h00000000;

   // bus answer: ack one cycle after the request, unmapped reads give zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req & ~wb_we_i) ? rd_val : 32'h00000000;
      end
   end

   // control store writes through byte lanes
   always_ff @(posedge clk) begin
      if (wr && cs_hit) begin
         control_store[idx[4:0]] <= (control_store[idx[4:0]] & ~lane_m[CS_W-1:0]) |
                                    (wb_dat_i[CS_W-1:0] & lane_m[CS_W-1:0]);
      end
   end

   // software registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         split_en <= 1'b0;
         branch <= PC_START;
         pend_dir <= 1'b0;
      end else begin
         if (wr && idx == IX_AUX && wb_sel_i[0]) begin
            split_en <= wb_dat_i[A_SPLIT_EN];
         end
         if (wr && idx == IX_BRANCH && wb_sel_i[0]) begin
            branch <= wb_dat_i[4:0];
         end
         if (go_wr) begin
            pend_dir <= wb_dat_i[G_WRITE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer core
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run <= 1'b0;
         pc <= PC_START;
         cnt <= 8'h00;
         dir_wr <= 1'b0;
         restart <= 1'b0;
      end else begin
         run <= launch | (run & ~stop_now);
         if (load) begin
            pc <= next_pc;
            cnt <= control_store[next_pc][W_CNT+:8];
         end else if (byte_ev) begin
            cnt <= cnt - 8'h01;
         end
         if (launch) begin
            dir_wr <= launch_dir;
         end
         // a start arriving mid-sector waits for the sector end
         if (go_wr && run && !stop_now) begin
            restart <= 1'b1;
         end else if (stop_now) begin
            restart <= 1'b0;
         end
      end
   end

   // ecc freeze state and first-section tracking
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frozen <= 1'b0;
         first_sec <= 1'b1;
      end else if (launch || term) begin
         frozen <= 1'b0;
         first_sec <= 1'b1;
      end else if (freeze) begin
         frozen <= 1'b1;
         first_sec <= 1'b0;
      end else if (resume) begin
         frozen <= 1'b0;
      end
   end

   // syndrome capture one cycle after termination, once the last byte is in
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         term_q <= 1'b0;
         synd <= 32'h00000000;
         ecc_err <= 1'b0;
      end else begin
         term_q <= term;
         if (term_q) begin
            synd <= ecc_q;
            ecc_err <= (ecc_q != ECC_SEED);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // disk and buffer side outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         buf_out_push <= 1'b0;
         buf_out_data <= 8'h00;
         buf_in_take <= 1'b0;
         disk_wr_data <= 8'h00;
         disk_read_gate <= 1'b0;
         disk_write_gate <= 1'b0;
         xact <= 1'b0;
         seq_done <= 1'b0;
      end else begin
         buf_out_push <= byte_ev & ~dir_wr & w_xfer;
         buf_in_take <= byte_ev & dir_wr & w_xfer;
         if (byte_ev && !dir_wr && w_xfer) begin
            buf_out_data <= rd_s2;
         end
         // sync and address mark bytes come from the word's data field
         if (byte_ev && dir_wr) begin
            disk_wr_data <= w_xfer ? buf_in_data : w_dat;
         end
         disk_read_gate <= run & w_gate & ~dir_wr;
         disk_write_gate <= run & w_gate & dir_wr;
         xact <= run & w_xfer;
         seq_done <= stop_now;
      end
   end

   sfe_ecc u_ecc (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(ecc_clr),
      .feed(ecc_feed),
      .data_byte(ecc_byte),
      .ecc(ecc_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_flag_xfer_end;
      word_end && w_xfer && split_act;
   endsequence

   split_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(frozen) |-> $past(split_en))
      else $error("ecc froze with split disabled");
   freeze_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(frozen) |-> $past(word_end && w_xfer && cur[C_SPLIT]))
      else $error("ecc froze without flagged transfer word");
   freeze_both_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_flag_xfer_end |=> frozen && !first_sec)
      else $error("flagged transfer end did not freeze");
   count_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      load |=> cnt == w_cnt)
      else $error("count not taken from word");
   ecc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      frozen && !ecc_clr |=> $stable(ecc_q))
      else $error("frozen ecc changed");
   mark_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
      byte_ev && w_am && !first_sec && !ecc_clr |=> $stable(ecc_q))
      else $error("later address mark entered ecc");
   jump_tgt_a: assert property (@(posedge clk) disable iff (sys_rst)
      word_end && !stop_now && !launch && w_nxt == JUMP_CODE |=> pc == $past(branch))
      else $error("jump missed branch target");
   xact_stat_a: assert property (@(posedge clk) disable iff (sys_rst)
      run && w_xfer && !launch && !stop_now |=> xact)
      else $error("transfer active bit not set");
   synd_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
      term_q |=> synd == $past(ecc_q))
      else $error("syndrome not captured");
   pc_range_a: assert property (@(posedge clk) disable iff (sys_rst)
      pc < JUMP_CODE)
      else $error("pc beyond control store");
   push_a: assert property (@(posedge clk) disable iff (sys_rst)
      byte_ev && w_xfer && !dir_wr |=> buf_out_push ##1 !buf_out_push || byte_ev)
      else $error("transfer byte not pushed");
endmodule // sfe_seq

// >>> include/sfe_pkg.sv
// sfe_pkg: register indices, field positions and constants of the split field sequencer.
// assumes: registers sit on a 32-bit classic wishbone bus, byte address = 4 * index.
package sfe_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] IX_AUX = 8'h48;
   localparam logic [7:0] IX_BRANCH = 8'h78;
   localparam logic [7:0] IX_STATUS = 8'h79;
   localparam logic [7:0] IX_START = 8'h7b;
   localparam logic [7:0] IX_SYND = 8'h7c;
   localparam logic [7:0] IX_CS_END = 8'h1f;
   localparam int ADR_LO = 2;
   localparam int ADR_HI = 9;
   // control store geometry and word layout
   localparam int CS_DEPTH = 31;
   localparam int CS_W = 29;
   localparam int W_CNT = 8;
   localparam int W_NXT = 16;
   localparam int W_DAT = 21;
   localparam logic [4:0] JUMP_CODE = 5'h1f;
   localparam logic [4:0] PC_START = 5'h00;
   // control field bits
   localparam int C_XFER = 0;
   localparam int C_GATE = 2;
   localparam int C_SPLIT = 3;
   localparam int C_AM = 5;
   localparam int C_STOP = 7;
   // register bits
   localparam int A_SPLIT_EN = 7;
   localparam int S_ERR = 0;
   localparam int S_XACT = 6;
   localparam int S_RUN = 7;
   localparam int G_GO = 0;
   localparam int G_WRITE = 1;
   // ecc generator
   localparam logic [31:0] ECC_POLY = 32'h04c11db7;
   localparam logic [31:0] ECC_SEED = 32'h00000000;
endpackage

// >>> verification/sfe_disk_model.sv
// sfe_disk_model: drive channel stand-in with a free running byte tick and read bytes.
// assumes: the sequencer synchronises tick and data with two flops on clk.
`timescale 1ns/10ps
module sfe_disk_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic [7:0] skip,
   input wire logic disk_read_gate,
   input wire logic sector_end,
   output logic disk_byte_tick,
   output logic [7:0] disk_rd_data
);
   logic [3:0] ph;
   logic [7:0] cnt;
   logic adv;
   logic [7:0] val;
   ////////////////////////////////////////////////////////////////////////////////
   // byte pattern; skip moves later bytes so split and unsplit runs see one payload
   assign val = 8'h30 + cnt + ((cnt > 8'h05) ? skip : 8'h00);
   // off the gate the line shows no stale byte
   assign disk_rd_data = (disk_read_gate || adv) ? val : ~val;
   // tick high four cycles, low four or ten; index moves after a gated byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph <= 4'h0;
         disk_byte_tick <= 1'b0;
         cnt <= 8'h00;
         adv <= 1'b0;
      end else begin
         ph <= ph + 4'h1;
         if (!disk_byte_tick && ph >= (slow ? 4'h9 : 4'h3)) begin
            disk_byte_tick <= 1'b1;
            ph <= 4'h0;
            adv <= disk_read_gate;
         end else if (disk_byte_tick && ph == 4'h3) begin
            disk_byte_tick <= 1'b0;
            ph <= 4'h0;
            cnt <= cnt + {7'h00, adv}; // data held through the sampling window
         end
         // each sector reads its pattern from the start again
         if (sector_end) begin
            cnt <= 8'h00;
         end
      end
   end
endmodule // sfe_disk_model

// >>> verification/split_field_ecc_sequencer_tb.sv
// split_field_ecc_sequencer_tb: register tasks and sector runs against the sequencer.
// assumes: sfe_pkg compiled first; channel model ticks freely.
`timescale 1ns/10ps
module split_field_ecc_sequencer_tb
   import sfe_pkg::*;
;
   localparam logic [7:0] XF = 8'(1 << C_XFER), GT = 8'(1 << C_GATE), SP = 8'(1 << C_SPLIT);
   localparam logic [7:0] AM = 8'(1 << C_AM), ST = 8'(1 << C_STOP);
   logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, slow = 0, clr = 0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, q, s1, rdat;
   logic [7:0] skip = 8'h00, bdat = 8'h00, rd, bout, wdo;
   logic ack, tick, gr, gw, take, push, done;
   logic [7:0] got[$], wq[$];
   int errors = 0, checked = 0, cyc_n = 0, dones = 0, bcnt = 0, lowc = 0, gap = 0;
   int gs = 0, wseen = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // clock, design and channel
   always #50 clk = ~clk;
   sfe_seq dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .disk_byte_tick(tick), .disk_rd_data(rd), .disk_wr_data(wdo), .disk_read_gate(gr),
      .disk_write_gate(gw), .buf_in_data(bdat), .buf_in_take(take), .buf_out_data(bout),
      .buf_out_push(push), .seq_done(done));
   sfe_disk_model chan (.clk(clk), .sys_rst(sys_rst), .slow(slow), .skip(skip),
      .disk_read_gate(gr), .sector_end(done), .disk_byte_tick(tick), .disk_rd_data(rd));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ex(input int i);
      return 8'h32 + 8'(i % 8) + (((i % 8) > 3) ? 8'h02 : 8'h00);
   endfunction
   function automatic logic [31:0] cw(input logic [7:0] c, n, input logic [4:0] nx,
      input logic [7:0] d);
      return {3'h0, d, nx, n, c};
   endfunction
   // watch pushes, stops, buffer takes, gap length; feed the buffer
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         errors++;
         $display("ERROR %0t ns: timeout", $time);
         test_done;
      end
      if (push === 1'b1) got.push_back(bout);
      if (take === 1'b1) wq.push_back(wdo);
      if (done === 1'b1) dones <= dones + 1;
      if (gw === 1'b1) wseen <= 1;
      bdat <= ex(bcnt);
      if (clr) begin
         bcnt <= 0;
         gap <= 0;
         lowc <= 0;
         gs <= 0;
      end else begin
         if (take === 1'b1) bcnt <= bcnt + 1;
         if (gr === 1'b1) begin
            gs <= 1;
            if (lowc > 0 && gap == 0) gap <= lowc;
            lowc <= 0;
         end else if (gs == 1) lowc <= lowc + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle, held until ack is sampled
   task wb(input logic w, input logic [7:0] ix, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      wdat <= d;
      sel <= 4'hf;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // start a sector, optionally queue a second one mid transfer, then read syndrome
   task run(input logic [31:0] go, input int chain);
      int d0;
      got.delete();
      wq.delete();
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      d0 = dones;
      wb(1'b1, IX_START, go);
      if (chain > 0) begin
         do wb(1'b0, IX_STATUS, 32'h0); while (q[S_XACT] !== 1'b1);
         wb(1'b1, IX_START, go);
      end
      while (dones < d0 + 1 + chain) @(posedge clk);
      wb(1'b0, IX_SYND, 32'h0);
   endtask
   task pushes(input int n);
      check(32'(got.size()), 32'(n));
      for (int i = 0; i < got.size(); i++) check({24'h0, got[i]}, {24'h0, ex(i)});
   endtask
   task test_done;
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check({27'h0, gr, gw, push, done, ack}, 32'h0);
      wb(1'b1, 8'h00, cw(8'h00, 8'h00, JUMP_CODE, 8'h00));
      wb(1'b1, 8'h01, cw(GT, 8'h00, 5'h02, 8'ha1));
      wb(1'b1, 8'h02, cw(GT | AM, 8'h00, 5'h03, 8'h31));
      wb(1'b1, 8'h03, cw(GT | XF | SP, 8'h03, 5'h04, 8'h00));
      wb(1'b1, 8'h04, cw(8'h00, 8'h02, 5'h05, 8'h00));
      wb(1'b1, 8'h05, cw(GT | SP, 8'h00, 5'h06, 8'ha1));
      wb(1'b1, 8'h06, cw(GT | AM | SP, 8'h00, 5'h07, 8'h31));
      wb(1'b1, 8'h07, cw(GT | XF, 8'h03, 5'h08, 8'h00));
      wb(1'b1, 8'h08, cw(ST, 8'h00, 5'h08, 8'h00));
      wb(1'b1, 8'h10, cw(GT, 8'h00, 5'h11, 8'ha1));
      wb(1'b1, 8'h11, cw(GT | AM, 8'h00, 5'h12, 8'h31));
      wb(1'b1, 8'h12, cw(GT | XF, 8'h07, 5'h13, 8'h00));
      wb(1'b1, 8'h13, cw(ST, 8'h00, 5'h13, 8'h00));
      wb(1'b1, 8'h1e, 32'hffffffff);
      wb(1'b0, 8'h1e, 32'h0);
      check(q, 32'h1fffffff);
      wb(1'b0, 8'h50, 32'h0);
      check(q, 32'h0);
      wb(1'b1, IX_AUX, 32'h80);
      wb(1'b0, IX_AUX, 32'h0);
      check({31'h0, q[A_SPLIT_EN]}, 32'h1);
      wb(1'b1, IX_BRANCH, 32'h1);
      wb(1'b0, IX_BRANCH, 32'h0);
      check(q, 32'h1);
      run(32'h1, 0);
      s1 = q;
      pushes(8);
      check(32'(gap), 32'd24);
      wb(1'b1, IX_BRANCH, 32'h10);
      skip <= 8'h02;
      run(32'h1, 0);
      pushes(8);
      check(q, s1);
      wb(1'b1, IX_BRANCH, 32'h1);
      slow <= 1'b1;
      run(32'h3, 0);
      slow <= 1'b0;
      check(q, s1);
      check(32'(wq.size()), 32'd8);
      for (int i = 0; i < 8; i++) check({24'h0, wq[i]}, {24'h0, ex(i)});
      check(32'(bcnt), 32'd8);
      check(32'(wseen), 32'd1);
      wb(1'b1, IX_AUX, 32'h0);
      skip <= 8'h00;
      run(32'h1, 0);
      check({31'h0, q !== s1}, 32'h1);
      wb(1'b1, IX_AUX, 32'h80);
      run(32'h1, 1);
      pushes(16);
      wb(1'b0, IX_STATUS, 32'h0);
      check({31'h0, q[S_RUN]}, 32'h0);
      test_done;
   end
endmodule // split_field_ecc_sequencer_tb
